// [core/dac_port_pkg.sv]
package dac_port_pkg;

  localparam int FRAME_BITS   = 24;
  localparam int CMD_BITS     = 8;
  localparam int DATA_BITS    = 16;
  localparam int COUNT_BITS   = 5;
  localparam int SYNC_WIDTH   = 6;

  // opcode sits in command bits 7:4, channel select in bits 2:0
  localparam int OPCODE_MSB   = 7;
  localparam int OPCODE_LSB   = 4;
  localparam int CHAN_MSB     = 2;
  localparam int CHAN_LSB     = 0;

  localparam logic [3:0] OP_WRITE          = 4'h1;
  localparam logic [3:0] OP_WRITE_UPDATE   = 4'h2;
  localparam logic [3:0] OP_WRITE_ALL      = 4'h3;
  localparam logic [3:0] OP_SOFT_LOAD      = 4'h4;
  localparam logic [3:0] OP_CLEAR          = 4'h5;
  localparam logic [3:0] OP_POWER_DOWN     = 4'h6;
  localparam logic [3:0] OP_SET_BLOCK      = 4'h7;
  localparam logic [3:0] OP_READ_PRELOAD   = 4'h8;
  localparam logic [3:0] OP_READ_OUTPUT    = 4'h9;
  localparam logic [3:0] OP_READ_CONFIG    = 4'hA;

  // configuration register layout
  localparam int CFG_PD_LSB   = 0;
  localparam int CFG_PD_MSB   = 1;
  localparam int CFG_WB_BIT   = 2;

  localparam logic [1:0] PD_ACTIVE   = 2'h0;
  localparam logic [1:0] PD_HIZ      = 2'h1;
  localparam logic [1:0] PD_PULLDOWN = 2'h2;

  localparam logic [23:0] SHIFT_RESET   = 24'h00_0000;
  localparam logic [15:0] CODE_ZERO     = 16'h0000;
  localparam logic [15:0] CODE_MID      = 16'h8000;
  localparam logic [7:0]  CONFIG_RESET  = 8'h00;
  localparam logic [15:0] CONFIG_PAD    = 16'h0000;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    logic [4:0] reserved;
    logic       write_block_bit;
    logic [1:0] power_down_mode;
  } config_t;

endpackage

// [core/dac_serial_command_port.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module dac_serial_command_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        chip_select_n,
  input  wire logic        serial_clock,
  input  wire logic        serial_data_in,
  input  wire logic        load_output_n,
  input  wire logic        clear_output_n,
  input  wire logic        powerup_level_select,
  output logic             serial_data_out,
  output logic             serial_data_out_oe_n,
  output logic [15:0]      output_code,
  output logic [15:0]      preload_code,
  output logic [1:0]       power_down_mode,
  output logic             write_block_bit
);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_FRAME  = 3'b010,
    ST_DECODE = 3'b100
  } state_t;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection

  logic [dac_port_pkg::SYNC_WIDTH-1:0] sync_q;
  logic        cs_s;
  logic        sclk_s;
  logic        sdi_s;
  logic        ld_s;
  logic        clr_s;
  logic        mz_s;
  logic        cs_prev_q;
  logic        sclk_prev_q;
  logic        cs_fall;
  logic        cs_rise;
  logic        sclk_rise;
  logic        sclk_fall;

  pin_sync #(
    .WIDTH (dac_port_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({chip_select_n, serial_clock, serial_data_in,
           load_output_n, clear_output_n, powerup_level_select}),
    .q   (sync_q)
  );

  assign {cs_s, sclk_s, sdi_s, ld_s, clr_s, mz_s} = sync_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // matches the synchroniser reset level so no false edge follows
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b1;
    end
    else
    begin
      cs_prev_q   <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign cs_fall   = cs_prev_q & ~cs_s;
  assign cs_rise   = ~cs_prev_q & cs_s;
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // frame control

  state_t                  state_q;
  logic [dac_port_pkg::COUNT_BITS-1:0] rise_cnt_q;
  logic                    frame_full;
  logic [23:0]             shift_q;
  logic                    sdo_q;

  // the count only qualifies a frame; it never starts a decode
  assign frame_full = (rise_cnt_q ==
    dac_port_pkg::COUNT_BITS'(dac_port_pkg::FRAME_BITS));

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cs_fall)
            state_q <= ST_FRAME;
        ST_FRAME:
          if (cs_rise)
            state_q <= frame_full ? ST_DECODE : ST_IDLE;
        ST_DECODE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || (state_q == ST_IDLE))
      rise_cnt_q <= '0;
    else if (state_q == ST_FRAME && sclk_rise && !frame_full)
      rise_cnt_q <= rise_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // command decode

  dac_port_pkg::frame_t  frame;
  dac_port_pkg::config_t cfg_q;
  logic [3:0]            opcode;
  logic                  chan_ok;
  logic                  exec;
  logic [15:0]           preload_q;
  logic [15:0]           output_q;
  logic [15:0]           output_d;
  logic [15:0]           clear_level;

  function automatic logic channel_zero(input logic [7:0] cmd);
    return cmd[dac_port_pkg::CHAN_MSB:dac_port_pkg::CHAN_LSB] == 3'h0;
  endfunction

  function automatic logic is_write(input logic [3:0] op);
    return (op == dac_port_pkg::OP_WRITE) ||
           (op == dac_port_pkg::OP_WRITE_UPDATE) ||
           (op == dac_port_pkg::OP_WRITE_ALL);
  endfunction

  assign frame   = dac_port_pkg::frame_t'(shift_q);
  assign opcode  = frame.cmd[dac_port_pkg::OPCODE_MSB:
                             dac_port_pkg::OPCODE_LSB];
  assign chan_ok = channel_zero(frame.cmd) ||
                   (opcode == dac_port_pkg::OP_WRITE_ALL);
  // only accepted frames reach decode, so aborts cannot write
  assign exec    = (state_q == ST_DECODE) && chan_ok;
  assign clear_level = mz_s ? dac_port_pkg::CODE_MID
                            : dac_port_pkg::CODE_ZERO;

  always_ff @(posedge clk)
  begin
    if (rst)
      preload_q <= dac_port_pkg::CODE_ZERO;
    else if (exec && is_write(opcode))
      preload_q <= frame.data;
  end

  always_comb
  begin
    output_d = output_q;
    if (exec)
    begin
      case (opcode)
        dac_port_pkg::OP_WRITE:
          if (cfg_q.write_block_bit)
            output_d = frame.data;
        dac_port_pkg::OP_WRITE_UPDATE,
        dac_port_pkg::OP_WRITE_ALL:
          output_d = frame.data;
        dac_port_pkg::OP_SOFT_LOAD:
          output_d = preload_q;
        dac_port_pkg::OP_CLEAR:
          output_d = clear_level;
        default:
          output_d = output_q;
      endcase
    end
    // level sensitive; a held-low pin follows a fresh preload too
    if (!ld_s)
      output_d = (exec && is_write(opcode)) ?
                 frame.data : preload_q;
    if (!clr_s)
      output_d = clear_level;
  end

  // clocked load one cycle after reset release uses the synchroniser reset level (mid-scale), not the strap
  logic init_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      init_q <= 1'b1;
    else
      init_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      output_q <= dac_port_pkg::CODE_ZERO;
    else if (init_q)
      output_q <= clear_level;
    else
      output_q <= output_d;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cfg_q <= dac_port_pkg::config_t'(dac_port_pkg::CONFIG_RESET);
    else if (exec && opcode == dac_port_pkg::OP_POWER_DOWN)
      cfg_q.power_down_mode <= frame.data[dac_port_pkg::CFG_PD_MSB:
                                          dac_port_pkg::CFG_PD_LSB];
    else if (exec && opcode == dac_port_pkg::OP_SET_BLOCK)
      cfg_q.write_block_bit <= frame.data[0];
  end

  ////////////////////////////////////////////////////////////////////////
  // shift register and serial output

  always_ff @(posedge clk)
  begin
    if (rst)
      shift_q <= dac_port_pkg::SHIFT_RESET;
    else if (state_q == ST_FRAME && sclk_rise)
      shift_q <= {shift_q[22:0], sdi_s};
    else if (exec)
    begin
      // command byte stays in place for the echo
      case (opcode)
        dac_port_pkg::OP_READ_PRELOAD:
          shift_q[15:0] <= preload_q;
        dac_port_pkg::OP_READ_OUTPUT:
          shift_q[15:0] <= output_q;
        dac_port_pkg::OP_READ_CONFIG:
          shift_q[15:0] <= dac_port_pkg::CONFIG_PAD | 16'(cfg_q);
        default:
          shift_q <= shift_q;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sdo_q <= 1'b0;
    else if (state_q == ST_IDLE && cs_fall)
      sdo_q <= shift_q[23];
    else if (state_q == ST_FRAME && sclk_fall && rise_cnt_q != '0)
      sdo_q <= shift_q[23];
  end

  assign serial_data_out      = sdo_q;
  assign serial_data_out_oe_n = (state_q != ST_FRAME);
  assign output_code          = output_q;
  assign preload_code         = preload_q;
  assign power_down_mode      = cfg_q.power_down_mode;
  assign write_block_bit      = cfg_q.write_block_bit;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_accept;
    state_q == ST_FRAME && cs_rise && frame_full;
  endsequence

  sequence s_plain_write_through;
    exec && opcode == dac_port_pkg::OP_WRITE && cfg_q.write_block_bit
      && clr_s;
  endsequence

  property p_sdo_hiz;
    state_q != ST_FRAME |-> serial_data_out_oe_n;
  endproperty
  a_sdo_hiz: assert property (p_sdo_hiz)
    else $error("serial output driven outside a frame");

  property p_capture;
    state_q == ST_FRAME && sclk_rise
      |=> shift_q[0] == $past(sdi_s) && shift_q[23:1] == $past(shift_q[22:0]);
  endproperty
  a_capture: assert property (p_capture)
    else $error("input bit not shifted in on clock rise");

  property p_sdo_fall;
    state_q == ST_FRAME && sclk_fall && rise_cnt_q != '0
      |=> serial_data_out == $past(shift_q[23]);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("serial output not updated on clock fall");

  property p_cs_fall_msb;
    state_q == ST_IDLE && cs_fall
      |=> serial_data_out == $past(shift_q[23]) && !serial_data_out_oe_n;
  endproperty
  a_cs_fall_msb: assert property (p_cs_fall_msb)
    else $error("msb not presented at frame start");

  property p_abort;
    state_q == ST_FRAME && cs_rise && !frame_full
      |=> state_q == ST_IDLE ##1 $stable(preload_q) && $stable(cfg_q);
  endproperty
  a_abort: assert property (p_abort)
    else $error("short frame was not discarded");

  property p_accept;
    s_accept |=> state_q == ST_DECODE ##1 state_q == ST_IDLE;
  endproperty
  a_accept: assert property (p_accept)
    else $error("full frame not decoded");

  property p_decode_cause;
    state_q == ST_DECODE |-> $past(cs_rise) && $past(frame_full);
  endproperty
  a_decode_cause: assert property (p_decode_cause)
    else $error("decode without chip select rise");

  property p_write_through;
    s_plain_write_through |=> output_q == $past(frame.data);
  endproperty
  a_write_through: assert property (p_write_through)
    else $error("write-through did not update output");

  property p_update_cmd;
    exec && clr_s && (opcode == dac_port_pkg::OP_WRITE_UPDATE ||
                      opcode == dac_port_pkg::OP_WRITE_ALL)
      |=> output_q == $past(frame.data) && preload_q == output_q;
  endproperty
  a_update_cmd: assert property (p_update_cmd)
    else $error("update command did not load both registers");

  property p_load_pin;
    !ld_s && clr_s && !exec && !init_q |=> output_q == $past(preload_q);
  endproperty
  a_load_pin: assert property (p_load_pin)
    else $error("load pin did not copy preload");

  property p_read_back;
    exec && opcode == dac_port_pkg::OP_READ_PRELOAD
      |=> shift_q[15:0] == $past(preload_q)
          && shift_q[23:16] == $past(shift_q[23:16]);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read did not load preload into shifter");

  property p_block_hold;
    exec && opcode == dac_port_pkg::OP_WRITE && !cfg_q.write_block_bit
      && ld_s && clr_s |=> $stable(output_q);
  endproperty
  a_block_hold: assert property (p_block_hold)
    else $error("write-block write changed output");

  property p_reset;
    disable iff (1'b0)
    rst |=> state_q == ST_IDLE && shift_q == dac_port_pkg::SHIFT_RESET;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not idle the port");

endmodule // dac_serial_command_port

// [core/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= '1;
      q      <= '1;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // pin_sync

// [testbench/serial_master.sv]
`timescale 1ns/1ps
module serial_master (
  input  wire logic clk,
  input  wire logic sdo_wire,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_data_in
);
  // half of the 160 ns link period, counted in 4 ns cycles
  localparam int HALF = 20;

  initial
  begin
    chip_select_n  = 1'b1;
    serial_clock   = 1'b0;
    serial_data_in = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // the link clock idles low and stands still between frames
  task automatic open_frame();
    @(negedge clk);
    chip_select_n = 1'b0;
    wait_clk(HALF);
  endtask

  // sdo is sampled at the rise, half a period after the device moved it
  task automatic bit_step(input logic b, output logic r);
    serial_data_in = b;
    wait_clk(HALF / 2);
    r = sdo_wire;
    serial_clock = 1'b1;
    wait_clk(HALF);
    serial_clock = 1'b0;
    wait_clk(HALF / 2);
  endtask

  // data line flips on release so a stale bit cannot pass for a real one
  task automatic close_frame();
    wait_clk(HALF / 2);
    chip_select_n  = 1'b1;
    serial_data_in = ~serial_data_in;
    wait_clk(HALF);
  endtask

  task automatic send24(input logic [23:0] tx, output logic [23:0] rx);
    open_frame();
    for (int i = 23; i >= 0; i--)
      bit_step(tx[i], rx[i]);
    close_frame();
  endtask
endmodule // serial_master

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst, chip_select_n, serial_clock, serial_data_in;
  logic        load_output_n, clear_output_n, powerup_level_select;
  logic        serial_data_out, serial_data_out_oe_n, write_block_bit;
  logic [15:0] output_code, preload_code, pre_e, out_e;
  logic [1:0]  power_down_mode, pd_e;
  logic        wb_e;
  logic [23:0] shadow, rx, tx;
  logic [47:0] rx_long, tx_long;
  wire         sdo_wire;
  int          fails, total_checks;

  assign sdo_wire = serial_data_out_oe_n ? 1'bz : serial_data_out;

  dac_serial_command_port uut (
    .clk(clk), .rst(rst), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in),
    .load_output_n(load_output_n), .clear_output_n(clear_output_n),
    .powerup_level_select(powerup_level_select),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n),
    .output_code(output_code), .preload_code(preload_code),
    .power_down_mode(power_down_mode), .write_block_bit(write_block_bit)
  );

  serial_master host (
    .clk(clk), .sdo_wire(sdo_wire), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_state();
    check({output_code, preload_code}, {out_e, pre_e}, "codes");
    check({29'h0000_0000, power_down_mode, write_block_bit},
          {29'h0000_0000, pd_e, wb_e}, "config");
    check({31'h0000_0000, sdo_wire}, {31'h0000_0000, 1'bz}, "sdo idle");
  endtask

  // one full frame; the bits coming back must be the previous contents
  task automatic frame(input logic [3:0] op, input logic [15:0] data);
    tx = {op, 4'h0, data};
    host.send24(tx, rx);
    check({8'h00, rx}, {8'h00, shadow}, "shifted out");
    shadow = tx;
    case (op)
      dac_port_pkg::OP_WRITE:
      begin
        pre_e = data;
        if (wb_e || !load_output_n)
          out_e = data;
      end
      dac_port_pkg::OP_WRITE_UPDATE,
      dac_port_pkg::OP_WRITE_ALL:
      begin
        pre_e = data;
        out_e = data;
      end
      dac_port_pkg::OP_SOFT_LOAD:    out_e = pre_e;
      dac_port_pkg::OP_POWER_DOWN:   pd_e = data[1:0];
      dac_port_pkg::OP_SET_BLOCK:    wb_e = data[0];
      dac_port_pkg::OP_READ_PRELOAD: shadow[15:0] = pre_e;
      dac_port_pkg::OP_READ_OUTPUT:  shadow[15:0] = out_e;
      dac_port_pkg::OP_READ_CONFIG:  shadow[15:0] = {13'h0000, wb_e, pd_e};
      default: ;
    endcase
    check_state();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_write_modes();
    frame(dac_port_pkg::OP_WRITE, 16'h1234);
    frame(dac_port_pkg::OP_SOFT_LOAD, 16'h0000);
    frame(dac_port_pkg::OP_WRITE_UPDATE, 16'hA5C3);
    frame(dac_port_pkg::OP_WRITE, 16'h5A5A);
    frame(dac_port_pkg::OP_WRITE_ALL, 16'h0F0F);
    frame(dac_port_pkg::OP_SET_BLOCK, 16'h0001);
    frame(dac_port_pkg::OP_WRITE, 16'hBEEF);
  endtask

  // reads back to back: each frame echoes the one before it
  task automatic t_reads();
    frame(dac_port_pkg::OP_WRITE_UPDATE, 16'hC001);
    frame(dac_port_pkg::OP_SET_BLOCK, 16'h0000);
    frame(dac_port_pkg::OP_WRITE, 16'h00FF);
    frame(dac_port_pkg::OP_READ_PRELOAD, 16'hFFFF);
    frame(dac_port_pkg::OP_READ_OUTPUT, 16'hFFFF);
    frame(dac_port_pkg::OP_READ_CONFIG, 16'hFFFF);
    frame(dac_port_pkg::OP_POWER_DOWN, {14'h0000, dac_port_pkg::PD_PULLDOWN});
    frame(dac_port_pkg::OP_READ_CONFIG, 16'h0000);
    frame(dac_port_pkg::OP_POWER_DOWN, {14'h0000, dac_port_pkg::PD_HIZ});
    frame(dac_port_pkg::OP_READ_CONFIG, 16'h0000);
    frame(dac_port_pkg::OP_POWER_DOWN, {14'h0000, dac_port_pkg::PD_ACTIVE});
  endtask

  // select rises after 23 rising edges: no code or config may change
  task automatic t_abort();
    tx = {dac_port_pkg::OP_WRITE_UPDATE, 4'h0, 16'h7777};
    host.open_frame();
    for (int i = 23; i >= 1; i--)
      host.bit_step(tx[i], rx[i]);
    host.close_frame();
    check({9'h000, rx[23:1]}, {9'h000, shadow[23:1]}, "abort out");
    shadow = {shadow[0], tx[23:1]};
    check_state();
  endtask

  // 48 clocks: the first 24 bits reappear, only the last 24 decode
  task automatic t_long();
    tx_long = {dac_port_pkg::OP_WRITE_ALL, 4'h0, 16'hDEAD,
               dac_port_pkg::OP_WRITE_UPDATE, 4'h0, 16'h2468};
    host.open_frame();
    for (int i = 47; i >= 0; i--)
      host.bit_step(tx_long[i], rx_long[i]);
    host.close_frame();
    check({8'h00, rx_long[47:24]}, {8'h00, shadow}, "long head");
    check({8'h00, rx_long[23:0]}, {8'h00, tx_long[47:24]}, "flow");
    shadow = tx_long[23:0];
    pre_e = 16'h2468;
    out_e = 16'h2468;
    check_state();
  endtask

  task automatic t_pins();
    frame(dac_port_pkg::OP_WRITE, 16'h1357);
    @(negedge clk);
    load_output_n = 1'b0;
    repeat (8) @(negedge clk);
    out_e = pre_e;
    check_state();
    frame(dac_port_pkg::OP_WRITE, 16'h2222);
    load_output_n = 1'b1;
    clear_output_n = 1'b0;
    repeat (8) @(negedge clk);
    out_e = dac_port_pkg::CODE_MID;
    check_state();
    powerup_level_select = 1'b0;
    repeat (8) @(negedge clk);
    out_e = dac_port_pkg::CODE_ZERO;
    check_state();
    clear_output_n = 1'b1;
    repeat (8) @(negedge clk);
    frame(dac_port_pkg::OP_READ_OUTPUT, 16'h0000);
    frame(dac_port_pkg::OP_READ_CONFIG, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    load_output_n = 1'b1;
    clear_output_n = 1'b1;
    powerup_level_select = 1'b1;
    shadow = dac_port_pkg::SHIFT_RESET;
    pre_e = dac_port_pkg::CODE_ZERO;
    out_e = dac_port_pkg::CODE_MID;
    pd_e = dac_port_pkg::PD_ACTIVE;
    wb_e = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check_state();
    t_write_modes();
    t_reads();
    t_abort();
    t_long();
    t_pins();
    complete_run();
  end

  // a hung run is cut short and judged a failure
  initial
  begin
    repeat (95000) @(posedge clk);
    fails++;
    $display("wrong value at %0t: run limit reached", $time);
    complete_run();
  end
endmodule // tb_top
